// File: spc2_ctrl.sv
// Serial port control block: control register two with its interrupt
// enables, transmitter/receiver enables, standby, break queue, pin ownership.
// Assumes a single-master register port and a remote node on the lines.
//
// The placing of the registers and the address-and-strobe port were left to the implementer.
`default_nettype none
`include "spc2_regs.svh"

module spc2_ctrl
(
  // Clock and reset
  input  wire logic       ref_clk_i,
  input  wire logic       arst_n_i,
  // Register port
  input  wire logic [3:0] addr_i,
  input  wire logic [7:0] wdata_i,
  input  wire logic       wr_i,
  input  wire logic       rd_i,
  output logic      [7:0] rdata_o,
  // Transmit side
  input  wire logic [8:0] tx_data_i,
  input  wire logic       tx_valid_i,
  output logic            tx_ready_o,
  // Receive side
  output logic      [8:0] rx_data_o,
  output logic            rx_valid_o,
  input  wire logic       rx_read_i,
  // Serial output pin
  input  wire logic       serial_out_pin_i,
  output logic            serial_out_pin_o,
  output logic            serial_out_pin_oe_o,
  // Serial input pin
  input  wire logic       serial_in_pin_i,
  output logic            serial_in_gpio_o,
  // Interrupts
  output logic            serial_irq_o,
  output logic            event_irq_o
);
  import spc2_pkg::*;

  // ============================================================
  // Registers and decode
  logic [7:0] ctrl2;
  logic [7:0] ctrl1;
  logic [7:0] evt_sts;
  logic [7:0] evt_mask;
  logic       tx_buffer_empty;
  logic       tx_done;
  logic       rx_buffer_full;
  logic       line_quiet_flag;

  function automatic logic hit(input logic [3:0] a, input logic [3:0] o);
    hit = (a == o);
  endfunction : hit

  wire wr_c2  = wr_i && hit(addr_i, `SPC2_OFS_CTRL2);
  wire wr_c1  = wr_i && hit(addr_i, `SPC2_OFS_CTRL1);
  wire wr_msk = wr_i && hit(addr_i, `SPC2_OFS_MASK);
  wire rd_irq = rd_i && hit(addr_i, `SPC2_OFS_IRQ);

  wire tx_on        = ctrl2[`SPC2_TX_ON];
  wire rx_on        = ctrl2[`SPC2_RX_ON];
  wire break_queue  = ctrl2[`SPC2_BRK_Q];
  wire loopback_sel = ctrl1[`SPC2_LOOP];
  wire rx_src_sel   = ctrl1[`SPC2_RXSRC];
  wire nine_bit     = ctrl1[`SPC2_NINE];
  wire rouse_method = ctrl1[`SPC2_ROUSE];
  wire single_dir   = ctrl1[`SPC2_SWDIR];
  wire long_brk     = ctrl1[`SPC2_LONGBRK];
  wire single_wire  = loopback_sel && rx_src_sel;

  // ============================================================
  // Transmitter
  spc2_tx_state_t tx_state;
  spc2_tx_state_t next_tx_state;
  logic [15:0] bit_cnt;
  logic [3:0]  bit_idx;
  logic [10:0] tx_shift;
  logic        idle_pend;
  logic        brk_pend;
  logic        tx_owned;

  wire bit_end   = (bit_cnt == `SPC2_BIT_CYC);
  wire [3:0] ch_bits  = nine_bit ? 4'hB : 4'hA;
  wire [3:0] brk_bits = (long_brk ? `SPC2_LBRK_BITS : `SPC2_BRK_BITS)
                        + {3'h0, nine_bit};
  wire last_bit  = bit_end &&
                   (bit_idx == ((tx_state == SPC2_BREAK) ? brk_bits
                                                         : ch_bits) - 4'h1);
  wire tx_busy   = (tx_state != SPC2_IDLE);
  wire idle_req  = wr_c2 && !tx_on && wdata_i[`SPC2_TX_ON] && tx_busy;
  // break queued on write of one then zero
  wire brk_fall  = wr_c2 && break_queue && !wdata_i[`SPC2_BRK_Q];
  // transmitter only takes data while on
  wire tx_can    = tx_on && (!tx_busy || last_bit);
  assign tx_ready_o = tx_can && !brk_pend && !idle_pend && !break_queue;

  always_comb
  begin
    next_tx_state = tx_state;
    if (!tx_busy || last_bit)
    begin
      // breaks repeat while queue bit held
      if (brk_pend || (tx_on && break_queue))
        next_tx_state = SPC2_BREAK;
      else if (idle_pend)
        next_tx_state = SPC2_PREAM;
      else if (tx_can && tx_valid_i)
        next_tx_state = SPC2_DATA;
      else
        next_tx_state = SPC2_IDLE;
    end
  end

  wire start_ch = (!tx_busy || last_bit) && (next_tx_state != SPC2_IDLE);

  always_ff @(posedge ref_clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      tx_state  <= SPC2_IDLE;
      bit_cnt   <= 16'h0000;
      bit_idx   <= 4'h0;
      tx_shift  <= 11'h7FF;
      idle_pend <= 1'b0;
      brk_pend  <= 1'b0;
    end
    else
    begin
      tx_state <= next_tx_state;
      bit_cnt  <= (start_ch || bit_end) ? 16'h0000 : bit_cnt + 16'h0001;
      if (start_ch)
      begin
        bit_idx <= 4'h0;
        unique case (next_tx_state)
          SPC2_DATA:  tx_shift <= nine_bit ? {1'b1, tx_data_i, 1'b0}
                                           : {2'h3, tx_data_i[7:0], 1'b0};
          SPC2_BREAK: tx_shift <= 11'h000;
          default:    tx_shift <= 11'h7FF;
        endcase
      end
      else if (bit_end)
      begin
        bit_idx  <= bit_idx + 4'h1;
        tx_shift <= last_bit ? 11'h7FF
                  : (tx_state == SPC2_BREAK) ? 11'h000
                                             : {1'b1, tx_shift[10:1]};
      end
      if (idle_req)
        idle_pend <= 1'b1;
      else if (start_ch && next_tx_state == SPC2_PREAM)
        idle_pend <= 1'b0;
      if (brk_fall)
        brk_pend <= 1'b1;
      else if (start_ch && next_tx_state == SPC2_BREAK)
        brk_pend <= 1'b0;
    end
  end

  // pin held until pending traffic ends
  always_ff @(posedge ref_clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
      tx_owned <= 1'b0;
    else
      tx_owned <= tx_on || next_tx_state != SPC2_IDLE || idle_pend
                  || brk_pend;
  end

  // ============================================================
  // Pins
  // single-wire direction; receive drops drive
  wire tx_drive = tx_owned && (!single_wire || single_dir);
  always_ff @(posedge ref_clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      serial_out_pin_o    <= 1'b1;
      serial_out_pin_oe_o <= 1'b0;
    end
    else
    begin
      serial_out_pin_o    <= tx_shift[0];
      serial_out_pin_oe_o <= tx_drive;
    end
  end

  logic in_sync;
  logic out_sync;
  spc2_sync u_in_sync
  (
    .ref_clk_i (ref_clk_i),
    .arst_n_i  (arst_n_i),
    .async_i   (serial_in_pin_i),
    .sync_o    (in_sync)
  );
  spc2_sync u_out_sync
  (
    .ref_clk_i (ref_clk_i),
    .arst_n_i  (arst_n_i),
    .async_i   (serial_out_pin_i),
    .sync_o    (out_sync)
  );

  // input pin released when off or looped
  assign serial_in_gpio_o = !rx_on || loopback_sel;
  wire rx_line = !loopback_sel ? in_sync
               : (single_wire ? (tx_drive ? tx_shift[0] : out_sync)
                              : tx_shift[0]);

  // ============================================================
  // Receiver
  logic [15:0] rx_cnt;
  logic [3:0]  rx_idx;
  logic [9:0]  rx_shift;
  logic        rx_act;
  logic [3:0]  quiet_bits;
  logic        quiet_armed;
  logic        rx_standby;

  wire rx_mid   = (rx_cnt == (`SPC2_BIT_CYC >> 1));
  wire rx_bt    = (rx_cnt == `SPC2_BIT_CYC);
  wire rx_start = rx_on && !rx_act && !rx_line;
  wire rx_last  = rx_act && rx_mid && (rx_idx == ch_bits - 4'h1);
  wire [8:0] rx_word = nine_bit ? rx_shift[9:1]
                                : {1'b0, rx_shift[9:2]};
  wire rx_msb   = nine_bit ? rx_shift[9] : rx_shift[9];
  wire quiet_ev = rx_on && !rx_act && quiet_armed && rx_bt
                  && (quiet_bits == ch_bits - 4'h1);
  wire wake     = rouse_method ? (rx_last && rx_msb) : quiet_ev;
  wire rx_deliver = rx_last && !rx_standby;

  always_ff @(posedge ref_clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      rx_cnt      <= 16'h0000;
      rx_idx      <= 4'h0;
      rx_shift    <= 10'h000;
      rx_act      <= 1'b0;
      quiet_bits  <= 4'h0;
      quiet_armed <= 1'b0;
      rx_data_o   <= 9'h000;
    end
    else
    begin
      rx_cnt <= (rx_start || rx_bt || (!rx_act && !rx_line))
                ? 16'h0000 : rx_cnt + 16'h0001;
      if (rx_start)
      begin
        rx_act <= 1'b1;
        rx_idx <= 4'h0;
      end
      else if (rx_act && rx_mid)
      begin
        rx_shift <= {rx_line, rx_shift[9:1]};
        rx_idx   <= rx_idx + 4'h1;
        if (rx_last)
          rx_act <= 1'b0;
      end
      quiet_bits <= (rx_act || !rx_line) ? 4'h0
                  : (rx_bt ? quiet_bits + 4'h1 : quiet_bits);
      if (rx_last)
        quiet_armed <= 1'b1;
      else if (quiet_ev)
        quiet_armed <= 1'b0;
      if (rx_deliver)
        rx_data_o <= rx_word;
    end
  end

  // standby set by software, cleared on wakeup
  always_ff @(posedge ref_clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
      rx_standby <= 1'b0;
    else if (wake)
      rx_standby <= 1'b0;
    else if (wr_c2)
      rx_standby <= wdata_i[`SPC2_RX_STBY];
  end

  // ============================================================
  // Flags
  always_ff @(posedge ref_clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      rx_buffer_full  <= 1'b0;
      line_quiet_flag <= 1'b0;
    end
    else
    begin
      // Set wins over clear
      rx_buffer_full  <= rx_deliver || (rx_buffer_full && !rx_read_i);
      line_quiet_flag <= (quiet_ev && !rx_standby)
                         || (line_quiet_flag && !rx_read_i);
    end
  end
  assign rx_valid_o      = rx_buffer_full;
  assign tx_buffer_empty = tx_on && !(tx_busy && tx_state == SPC2_DATA
                                      && !last_bit);
  assign tx_done         = !tx_busy && !idle_pend && !brk_pend;

  assign serial_irq_o = (ctrl2[`SPC2_TXE_IE] && tx_buffer_empty)
                     || (ctrl2[`SPC2_TXD_IE] && tx_done)
                     || (ctrl2[`SPC2_RXF_IE] && rx_buffer_full)
                     || (ctrl2[`SPC2_LQ_IE]  && line_quiet_flag);

  // Sticky event copies, cleared by reading them once their flag has dropped
  wire [7:0] evt_set = {4'h0, line_quiet_flag, rx_buffer_full,
                        tx_done, tx_buffer_empty};
  always_ff @(posedge ref_clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
      evt_sts <= 8'h00;
    else
      evt_sts <= evt_set | (rd_irq ? 8'h00 : evt_sts);
  end
  assign event_irq_o = |(evt_sts & evt_mask);

  // ============================================================
  // Register writes and reads
  // no access restriction
  always_ff @(posedge ref_clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      ctrl2    <= `SPC2_CTRL2_RST;
      ctrl1    <= `SPC2_CTRL1_RST;
      evt_mask <= `SPC2_MASK_RST;
    end
    else
    begin
      if (wr_c2)
        ctrl2 <= {wdata_i[7:2], 1'b0, wdata_i[0]};
      if (wr_c1)
        ctrl1 <= {2'h0, wdata_i[5:0]};
      if (wr_msk)
        evt_mask <= {4'h0, wdata_i[3:0]};
    end
  end

  wire [7:0] ctrl2_view = {ctrl2[7:2], rx_standby, ctrl2[0]};
  wire [7:0] status     = {4'h0, line_quiet_flag, rx_buffer_full,
                           tx_done, tx_buffer_empty};
  wire [7:0] rd_mux =
    hit(addr_i, `SPC2_OFS_CTRL2)  ? ctrl2_view :
    hit(addr_i, `SPC2_OFS_CTRL1)  ? ctrl1 :
    hit(addr_i, `SPC2_OFS_STATUS) ? status :
    hit(addr_i, `SPC2_OFS_IRQ)    ? evt_sts :
    hit(addr_i, `SPC2_OFS_MASK)   ? evt_mask : 8'h00;

  always_ff @(posedge ref_clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
      rdata_o <= 8'h00;
    else
      rdata_o <= rd_i ? rd_mux : 8'h00;
  end
endmodule : spc2_ctrl

`default_nettype wire

// File: spc2_ctrl_checker.sv
// Port-level assertions for the serial port control block.
// Assumes it is bound to spc2_ctrl and sees only that module's ports.
`default_nettype none
`include "spc2_regs.svh"

module spc2_ctrl_checker
(
  // Clock and reset
  input wire logic       ref_clk_i,
  input wire logic       arst_n_i,
  // Register port
  input wire logic [3:0] addr_i,
  input wire logic [7:0] wdata_i,
  input wire logic       wr_i,
  input wire logic       rd_i,
  input wire logic [7:0] rdata_o,
  // Flags and pins
  input wire logic       rx_valid_o,
  input wire logic       rx_read_i,
  input wire logic       serial_out_pin_oe_o,
  input wire logic       serial_in_gpio_o,
  input wire logic       serial_irq_o,
  input wire logic       event_irq_o
);
  timeunit 1ns;
  timeprecision 1ns;
  import spc2_pkg::*;
  // ============================================================
  // Shadow of written registers, whole bytes; standby bit is left out of the readback check on purpose
  logic [7:0] ctl2;
  logic [7:0] ctl1;
  logic [7:0] msk;
  wire        sw = ctl1[`SPC2_LOOP] & ctl1[`SPC2_RXSRC];
  always_ff @(posedge ref_clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      ctl2 <= `SPC2_CTRL2_RST;
      ctl1 <= `SPC2_CTRL1_RST;
      msk <= `SPC2_MASK_RST;
    end
    else if (wr_i)
    begin
      case (addr_i)
        `SPC2_OFS_CTRL2: ctl2 <= wdata_i;
        `SPC2_OFS_CTRL1: ctl1 <= wdata_i;
        `SPC2_OFS_MASK:  msk <= wdata_i;
        default:         ;
      endcase
    end
  end
  // ============================================================
  // Assertions
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (!arst_n_i);
  chk_rdata_quiet: assert property (!$past(rd_i) |-> rdata_o == 8'h00)
    else $error("read data not zero outside read answer");
  chk_ctrl_back: assert property ($past(rd_i) && $past(addr_i) == 4'h0
    |-> rdata_o[7:2] == $past(ctl2[7:2])) else $error("ctrl2 readback");
  chk_irq_none: assert property (ctl2[7:4] == 4'h0 |-> !serial_irq_o)
    else $error("interrupt with all enables off");
  chk_irq_rx: assert property (ctl2[5] && rx_valid_o |-> serial_irq_o)
    else $error("receive-full interrupt missing");
  chk_gpio_loop: assert property (ctl1[0] |-> serial_in_gpio_o)
    else $error("input pin held in loop mode");
  chk_gpio_rx: assert property (!ctl1[0] |-> serial_in_gpio_o == !ctl2[2])
    else $error("input pin ownership wrong");
  chk_oe_tx_on: assert property ($past(ctl2[3], 2) && $past(ctl2[3])
    && ctl2[3] && !sw && !$past(sw) |-> serial_out_pin_oe_o)
    else $error("pin not driven");
  chk_oe_fall: assert property ($fell(serial_out_pin_oe_o)
    |-> !$past(ctl2[3]) || $past(sw)) else $error("pin released early");
  chk_rx_read: assert property (rx_read_i |=> !rx_valid_o)
    else $error("receive flag kept after read");
  chk_event_mask: assert property (msk == 8'h00 |-> !event_irq_o)
    else $error("event interrupt while masked");
  cover property (rx_valid_o && serial_irq_o);
  cover property ($fell(serial_out_pin_oe_o));
  cover property (event_irq_o);
endmodule : spc2_ctrl_checker

bind spc2_ctrl spc2_ctrl_checker u_spc2_ctrl_checker
(
  .ref_clk_i(ref_clk_i), .arst_n_i(arst_n_i), .addr_i(addr_i),
  .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
  .rx_valid_o(rx_valid_o), .rx_read_i(rx_read_i),
  .serial_out_pin_oe_o(serial_out_pin_oe_o),
  .serial_in_gpio_o(serial_in_gpio_o), .serial_irq_o(serial_irq_o),
  .event_irq_o(event_irq_o)
);
`default_nettype wire

// File: spc2_pkg.sv
// Types shared by the serial port control block.
// Assumes the constants header is on the include path.
`default_nettype none

package spc2_pkg;
  typedef enum logic [3:0] {
    SPC2_IDLE  = 4'h1,
    SPC2_DATA  = 4'h2,
    SPC2_PREAM = 4'h4,
    SPC2_BREAK = 4'h8
  } spc2_tx_state_t;
endpackage : spc2_pkg

`default_nettype wire

// File: spc2_regs.svh
// Register map, field positions and reset values of the serial port control
// block. Definitions only; included by the main module, the checker and the testbench.
`ifndef SPC2_REGS_SVH
`define SPC2_REGS_SVH

// ============================================================
// Register offsets
`define SPC2_OFS_CTRL2   4'h0
`define SPC2_OFS_CTRL1   4'h1
`define SPC2_OFS_STATUS  4'h2
`define SPC2_OFS_IRQ     4'h3
`define SPC2_OFS_MASK    4'h4

// ============================================================
// Control register two fields
`define SPC2_TXE_IE      7
`define SPC2_TXD_IE      6
`define SPC2_RXF_IE      5
`define SPC2_LQ_IE       4
`define SPC2_TX_ON       3
`define SPC2_RX_ON       2
`define SPC2_RX_STBY     1
`define SPC2_BRK_Q       0

// ============================================================
// Control register one fields (loop, source, width, wake, dir, long)
`define SPC2_LOOP        0
`define SPC2_RXSRC       1
`define SPC2_NINE        2
`define SPC2_ROUSE       3
`define SPC2_SWDIR       4
`define SPC2_LONGBRK     5

// ============================================================
// Reset values and timing counts
`define SPC2_CTRL2_RST   8'h00
`define SPC2_CTRL1_RST   8'h00
`define SPC2_MASK_RST    8'h00
`define SPC2_BIT_CYC     16'h01B2
`define SPC2_BRK_BITS    4'hA
`define SPC2_LBRK_BITS   4'hD

`endif

// File: spc2_remote.sv
// Remote serial node: sends 8N1 frames on the block's receive line.
// Assumes the bit time of the block, counted in ref_clk_i cycles.
`default_nettype none

module spc2_remote
(
  // Clock
  input wire logic ref_clk_i,
  // Receive line of the block, idles high
  output var logic line_o
);
  timeunit 1ns;
  timeprecision 1ns;
  localparam int BT = 435;
  initial line_o = 1'b1;
  // Start, data LSB first, stop
  task automatic send(input logic [7:0] ch);
    logic [9:0] fr;
    fr = {1'b1, ch, 1'b0};
    for (int i = 0; i < 10; i++)
    begin
      @(posedge ref_clk_i);
      line_o <= fr[i];
      repeat (BT - 1) @(posedge ref_clk_i);
    end
  endtask : send
endmodule : spc2_remote
`default_nettype wire

// File: spc2_sync.sv
// Two flip-flop synchroniser for one asynchronous pin level.
// Assumes the input comes from outside the ref_clk_i domain.
`default_nettype none

module spc2_sync
(
  // Clock and reset
  input  wire logic ref_clk_i,
  input  wire logic arst_n_i,
  // Level
  input  wire logic async_i,
  output logic      sync_o
);
  logic meta;

  always_ff @(posedge ref_clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      meta   <= 1'b1;
      sync_o <= 1'b1;
    end
    else
    begin
      meta   <= async_i;
      sync_o <= meta;
    end
  end
endmodule : spc2_sync

`default_nettype wire

// File: testbench.sv
// Testbench of the serial port control block: register tasks and scenarios.
// Assumes spc2_remote on the receive line and a pull-up on the output pin.
`default_nettype none
`include "spc2_regs.svh"

module testbench;
  timeunit 1ns;
  timeprecision 1ns;
  import spc2_pkg::*;
  localparam int BT = 435;
  localparam logic [7:0] IE_TAB [4] = '{8'h40, 8'h80, 8'h88, 8'h08};
  localparam logic [3:0] IE_RES = 4'b0101;
  logic       ref_clk_i = 1'b0;
  logic       arst_n_i = 1'b0;
  logic [3:0] addr = 4'h0;
  logic [7:0] wdata = 8'h00;
  logic       wr = 1'b0;
  logic       rd = 1'b0;
  logic [8:0] txd = 9'h000;
  logic       txv = 1'b0;
  logic       rxr = 1'b0;
  logic [7:0] rdata;
  logic [8:0] rxd;
  logic       txr, rxv, po, poe, rline, gpio, sirq, eirq;
  logic [9:0] fr;
  wire        pin = poe ? po : 1'b1;
  int         bad_count = 0;
  int         check_count = 0;
  int         n;
  always #10 ref_clk_i = ~ref_clk_i;

  spc2_ctrl u_spc2_ctrl
  (
    .ref_clk_i(ref_clk_i), .arst_n_i(arst_n_i), .addr_i(addr),
    .wdata_i(wdata), .wr_i(wr), .rd_i(rd), .rdata_o(rdata),
    .tx_data_i(txd), .tx_valid_i(txv), .tx_ready_o(txr),
    .rx_data_o(rxd), .rx_valid_o(rxv), .rx_read_i(rxr),
    .serial_out_pin_i(pin), .serial_out_pin_o(po),
    .serial_out_pin_oe_o(poe), .serial_in_pin_i(rline),
    .serial_in_gpio_o(gpio), .serial_irq_o(sirq), .event_irq_o(eirq)
  );
  spc2_remote u_spc2_remote (.ref_clk_i(ref_clk_i), .line_o(rline));

  // ============================================================
  // Tasks
  task automatic summarize();
    $display("checks %0d mismatches %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : summarize
  task automatic ck(input logic [8:0] got, input logic [8:0] exp);
    check_count++;
    if (got !== exp)
    begin
      bad_count++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask : ck
  task automatic hang();
    bad_count++;
    $display("[FAIL] %0t wait ran out", $time);
    summarize();
  endtask : hang
  task automatic wr_reg(input logic [3:0] a, input logic [7:0] d);
    @(posedge ref_clk_i);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge ref_clk_i);
    wr <= 1'b0;
    #1;
  endtask : wr_reg
  task automatic rd_ck(input logic [3:0] a, input logic [7:0] e, m);
    @(posedge ref_clk_i);
    addr <= a;
    rd <= 1'b1;
    @(posedge ref_clk_i);
    rd <= 1'b0;
    #1;
    ck(9'(rdata & m), 9'(e));
  endtask : rd_ck
  // Valid held until ready is seen, then dropped on the taking edge
  task automatic tx_put(input logic [8:0] d);
    @(posedge ref_clk_i);
    txd <= d;
    txv <= 1'b1;
    for (n = 0; n < 100; n++)
    begin
      @(negedge ref_clk_i);
      if (txr === 1'b1)
        break;
    end
    if (n == 100)
      hang();
    @(posedge ref_clk_i);
    txv <= 1'b0;
  endtask : tx_put
  task automatic rx_pop();
    @(posedge ref_clk_i);
    rxr <= 1'b1;
    @(posedge ref_clk_i);
    rxr <= 1'b0;
    #1;
  endtask : rx_pop
  // Long bound covers a queued idle preamble first
  task automatic till_low();
    for (n = 0; n < 12 * BT; n++)
    begin
      @(negedge ref_clk_i);
      if (pin === 1'b0)
        break;
    end
    if (n == 12 * BT)
      hang();
  endtask : till_low

  // ============================================================
  // Scenarios
  initial
  begin
    repeat (8) @(posedge ref_clk_i);
    arst_n_i <= 1'b1;
    ck(9'({poe, gpio, sirq, eirq}), 9'h004);
    wr_reg(`SPC2_OFS_CTRL2, 8'hF4);
    wr_reg(4'hF, 8'h55);
    rd_ck(`SPC2_OFS_CTRL2, 8'hF4, 8'hFF);
    rd_ck(4'hF, 8'h00, 8'hFF);
    foreach (IE_TAB[i])
    begin
      wr_reg(`SPC2_OFS_CTRL2, IE_TAB[i]);
      ck(9'(sirq), 9'(IE_RES[i]));
    end
    @(negedge ref_clk_i);
    ck(9'(poe), 9'h001);
    tx_put(9'h035);
    // Transmitter off while the character is still pending
    wr_reg(`SPC2_OFS_CTRL2, 8'h00);
    till_low();
    fr = {1'b1, 8'h35, 1'b0};
    repeat (BT / 2) @(negedge ref_clk_i);
    for (int b = 0; b < 10; b++)
    begin
      ck(9'({poe, pin}), 9'({1'b1, fr[b]}));
      repeat (BT) @(negedge ref_clk_i);
    end
    for (n = 0; n < 2 * BT && poe !== 1'b0; n++) @(negedge ref_clk_i);
    ck(9'(poe), 9'h000);
    wr_reg(`SPC2_OFS_CTRL2, 8'h08);
    tx_put(9'h0C3);
    // Off then on while the character is out queues one idle character
    wr_reg(`SPC2_OFS_CTRL2, 8'h00);
    wr_reg(`SPC2_OFS_CTRL2, 8'h08);
    repeat (11 * BT) @(negedge ref_clk_i);
    rd_ck(`SPC2_OFS_STATUS, 8'h00, 8'h02);
    repeat (10 * BT) @(negedge ref_clk_i);
    rd_ck(`SPC2_OFS_STATUS, 8'h02, 8'h02);
    for (int l = 0; l < 2; l++)
    begin
      wr_reg(`SPC2_OFS_CTRL1, 8'(l) << `SPC2_LONGBRK);
      wr_reg(`SPC2_OFS_CTRL2, 8'h09);
      wr_reg(`SPC2_OFS_CTRL2, 8'h08);
      till_low();
      for (n = 0; n < 30 * BT && pin === 1'b0; n++) @(negedge ref_clk_i);
      // One or two breaks both pass
      ck(9'(n >= (l ? 13 : 10) * BT - 4 && n <= (l ? 28 : 22) * BT),
         9'h001);
    end
    wr_reg(`SPC2_OFS_CTRL2, 8'h00);
    wr_reg(`SPC2_OFS_CTRL1, 8'h00);
    wr_reg(`SPC2_OFS_CTRL2, 8'h24);
    u_spc2_remote.send(8'hA5);
    for (n = 0; n < BT && rxv !== 1'b1; n++) @(negedge ref_clk_i);
    ck(9'({sirq, rxd[7:0]}), 9'h1A5);
    rd_ck(`SPC2_OFS_STATUS, 8'h06, 8'h07);
    wr_reg(`SPC2_OFS_MASK, 8'h04);
    ck(9'(eirq), 9'h001);
    rd_ck(`SPC2_OFS_IRQ, 8'h04, 8'h04);
    // Receive flag still standing sets its sticky copy again
    ck(9'(eirq), 9'h001);
    rx_pop();
    ck(9'({rxv, sirq}), 9'h000);
    rd_ck(`SPC2_OFS_IRQ, 8'h04, 8'h04);
    ck(9'(eirq), 9'h000);
    wr_reg(`SPC2_OFS_CTRL1, 8'h08);
    wr_reg(`SPC2_OFS_CTRL2, 8'h26);
    u_spc2_remote.send(8'h12);
    repeat (BT) @(negedge ref_clk_i);
    ck(9'(rxv), 9'h000);
    rd_ck(`SPC2_OFS_CTRL2, 8'h02, 8'h02);
    u_spc2_remote.send(8'h92);
    repeat (BT) @(negedge ref_clk_i);
    rd_ck(`SPC2_OFS_CTRL2, 8'h00, 8'h02);
    // Idle line after the waking character raises the quiet flag
    wr_reg(`SPC2_OFS_CTRL2, 8'h14);
    repeat (10 * BT) @(negedge ref_clk_i);
    ck(9'(sirq), 9'h001);
    rx_pop();
    ck(9'(sirq), 9'h000);
    wr_reg(`SPC2_OFS_CTRL1, 8'h01);
    ck(9'(gpio), 9'h001);
    wr_reg(`SPC2_OFS_CTRL1, 8'h00);
    ck(9'(gpio), 9'h000);
    wr_reg(`SPC2_OFS_CTRL2, 8'h00);
    ck(9'(gpio), 9'h001);
    summarize();
  end
endmodule : testbench
`default_nettype wire
